// file: rtl/ppfs_ahb_front.sv
// AHB-Lite slave front end: address phase capture, write strobe and read wait state
`timescale 1ns/1ns
module ppfs_ahb_front (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [ppfs_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic wr_pend_out,
  output logic rd_pend_out,
  output logic [ppfs_pkg::ADDR_W-1:0] addr_out
);
  typedef struct packed {
    logic ready;
    logic wr_pend;
    logic rd_pend;
    logic [ppfs_pkg::ADDR_W-1:0] addr;
  } ppfs_front_type;

  ppfs_front_type s_q;
  ppfs_front_type s_d;
  logic accept;

  // ==========================================================================
  // Address phase decode
  // Only NONSEQ is taken; single word transfers, so size is not checked
  assign accept = hsel_in && (htrans_in == ppfs_pkg::HTRANS_NONSEQ) && hready_in;

  // Reads take one wait state so a write in the previous data phase is visible
  always_comb begin
    s_d = s_q;
    s_d.wr_pend = accept && hwrite_in;
    s_d.rd_pend = accept && !hwrite_in;
    s_d.ready = !(accept && !hwrite_in);
    if (accept) begin
      s_d.addr = haddr_in;
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{ready: 1'b1, wr_pend: 1'b0, rd_pend: 1'b0, addr: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout_out = s_q.ready;
  assign wr_pend_out = s_q.wr_pend;
  assign rd_pend_out = s_q.rd_pend;
  assign addr_out = s_q.addr;

  // Every read is answered after exactly one low ready cycle
  AST_READ_WAIT: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state not one cycle");
endmodule // ppfs_ahb_front

// file: rtl/ppfs_pkg.sv
// Package: register map, field positions, reset values and widths of the pin-function block
package ppfs_pkg;
  // ==========================================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LOW_PINS = 6;
  localparam int PORT_PINS = 8;

  // ==========================================================================
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_LOW_DIR = 8'h00;
  localparam logic [7:0] OFS_LOW_DATA = 8'h04;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h08;
  localparam logic [7:0] OFS_FUNC_CTRL = 8'h0C;
  localparam logic [7:0] OFS_INT_SEL = 8'h10;
  localparam logic [7:0] OFS_P2_DIR = 8'h14;
  localparam logic [7:0] OFS_P2_DATA = 8'h18;
  localparam logic [7:0] OFS_P2_STATE = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int EXP_EN_BIT = 0;
  localparam int ADDR_OE_BIT = 0;

  // ==========================================================================
  // Reset values and fixed answers
  localparam logic [5:0] LOW_RST = 6'h00;
  localparam logic [5:0] INT_SEL_RST = 6'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [5:0] IRQ_IDLE = 6'h3F;
  localparam logic [31:0] WO_READ_VALUE = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// file: rtl/ppfs_top.sv
// Pin-function select for the six low pins of one port, plus a full second port
`timescale 1ns/1ns
module ppfs_top #(
  parameter int LOW_PINS = ppfs_pkg::LOW_PINS,
  parameter int PORT_PINS = ppfs_pkg::PORT_PINS
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [ppfs_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [ppfs_pkg::DATA_W-1:0] hwdata_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [ppfs_pkg::DATA_W-1:0] hrdata_out,
  // Low pins of the first port
  input wire logic [LOW_PINS-1:0] low_pin_in,
  output logic [LOW_PINS-1:0] low_pin_out,
  output logic [LOW_PINS-1:0] low_pin_oe_out,
  input wire logic [LOW_PINS-1:0] ext_addr_in,
  output logic [LOW_PINS-1:0] ext_int_req_n_out,
  // Second port pins
  input wire logic [PORT_PINS-1:0] second_port_pin_in,
  output logic [PORT_PINS-1:0] second_port_pin_out,
  output logic [PORT_PINS-1:0] second_port_pin_oe_out
);
  typedef struct packed {
    logic [LOW_PINS-1:0] low_dir;
    logic [LOW_PINS-1:0] low_data;
    logic exp_en;
    logic addr_oe;
    logic [LOW_PINS-1:0] int_sel;
    logic [PORT_PINS-1:0] p2_dir;
    logic [PORT_PINS-1:0] p2_data;
    logic [ppfs_pkg::DATA_W-1:0] rdata;
    logic [LOW_PINS-1:0] low_out;
    logic [LOW_PINS-1:0] low_oe;
    logic [LOW_PINS-1:0] irq_n;
    logic [PORT_PINS-1:0] p2_out;
    logic [PORT_PINS-1:0] p2_oe;
  } ppfs_state_type;

  ppfs_state_type s_q;
  ppfs_state_type s_d;
  logic wr_pend;
  logic rd_pend;
  logic [ppfs_pkg::ADDR_W-1:0] addr;
  logic wr_en;
  logic addr_mode;
  logic [PORT_PINS-1:0] p2_state;
  logic [ppfs_pkg::DATA_W-1:0] rd_mux;
  logic [LOW_PINS-1:0] low_oe_d;
  logic [LOW_PINS-1:0] low_out_d;
  logic [LOW_PINS-1:0] irq_n_d;

  // ==========================================================================
  // Bus front end
  ppfs_ahb_front u_front (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hready_in(hready_in),
    .hreadyout_out(hreadyout_out),
    .wr_pend_out(wr_pend),
    .rd_pend_out(rd_pend),
    .addr_out(addr)
  );

  // Write data is taken in the data phase, which is never stretched
  assign wr_en = wr_pend && hready_in;

  // ==========================================================================
  // Read path
  // Pin state mixes latched data for outputs and the live pin for inputs
  assign p2_state = (s_q.p2_dir & s_q.p2_data) | (~s_q.p2_dir & second_port_pin_in);
  assign addr_mode = s_q.exp_en && s_q.addr_oe;

  // Direction registers are write-only; reads never expose the stored bits
  always_comb begin
    rd_mux = ppfs_pkg::UNMAPPED_READ;
    case (addr)
      ppfs_pkg::OFS_LOW_DIR: rd_mux = ppfs_pkg::WO_READ_VALUE;
      ppfs_pkg::OFS_LOW_DATA: rd_mux = {26'h0, s_q.low_data};
      ppfs_pkg::OFS_MODE_CTRL: rd_mux = {31'h0, s_q.exp_en};
      ppfs_pkg::OFS_FUNC_CTRL: rd_mux = {31'h0, s_q.addr_oe};
      ppfs_pkg::OFS_INT_SEL: rd_mux = {26'h0, s_q.int_sel};
      ppfs_pkg::OFS_P2_DIR: rd_mux = ppfs_pkg::WO_READ_VALUE;
      ppfs_pkg::OFS_P2_DATA: rd_mux = {24'h0, s_q.p2_data};
      ppfs_pkg::OFS_P2_STATE: rd_mux = {24'h0, p2_state};
      default: rd_mux = ppfs_pkg::UNMAPPED_READ;
    endcase
  end

  // ==========================================================================
  // Next state: register writes and registered pin drive
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      case (addr)
        ppfs_pkg::OFS_LOW_DIR: s_d.low_dir = hwdata_in[LOW_PINS-1:0];
        ppfs_pkg::OFS_LOW_DATA: s_d.low_data = hwdata_in[LOW_PINS-1:0];
        ppfs_pkg::OFS_MODE_CTRL: s_d.exp_en = hwdata_in[ppfs_pkg::EXP_EN_BIT];
        ppfs_pkg::OFS_FUNC_CTRL: s_d.addr_oe = hwdata_in[ppfs_pkg::ADDR_OE_BIT];
        ppfs_pkg::OFS_INT_SEL: s_d.int_sel = hwdata_in[LOW_PINS-1:0];
        ppfs_pkg::OFS_P2_DIR: s_d.p2_dir = hwdata_in[PORT_PINS-1:0];
        ppfs_pkg::OFS_P2_DATA: s_d.p2_data = hwdata_in[PORT_PINS-1:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    // Read data loads in the wait state, after any earlier write landed
    if (rd_pend) begin
      s_d.rdata = rd_mux;
    end
    // Second port: internal direction copy sets the enables
    s_d.p2_oe = s_q.p2_dir;
    s_d.p2_out = s_q.p2_data;
    // Low pin drive, enable and request levels come from the per-pin loop below
    s_d.low_oe = low_oe_d;
    s_d.low_out = low_out_d;
    s_d.irq_n = irq_n_d;
  end

  // Per low pin: address output overrides direction, request routed unless deselected
  for (genvar n = 0; n < LOW_PINS; n++) begin : g_low
    // Plain nets here keep the next-state copy owned by a single process
    assign low_oe_d[n] = addr_mode || s_q.low_dir[n];
    assign low_out_d[n] = addr_mode ? ext_addr_in[n] : s_q.low_data[n];
    assign irq_n_d[n] = s_q.int_sel[n] ? 1'b1 : low_pin_in[n];
  end

  // State register; the pin outputs come straight from it
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{low_dir: ppfs_pkg::LOW_RST, low_data: ppfs_pkg::LOW_RST, exp_en: 1'b0,
               addr_oe: 1'b0, int_sel: ppfs_pkg::INT_SEL_RST, p2_dir: ppfs_pkg::PORT_RST,
               p2_data: ppfs_pkg::PORT_RST, rdata: '0, low_out: ppfs_pkg::LOW_RST,
               low_oe: ppfs_pkg::LOW_RST, irq_n: ppfs_pkg::IRQ_IDLE,
               p2_out: ppfs_pkg::PORT_RST, p2_oe: ppfs_pkg::PORT_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_out = s_q.rdata;
  assign hresp_out = ppfs_pkg::HRESP_OKAY;
  assign low_pin_out = s_q.low_out;
  assign low_pin_oe_out = s_q.low_oe;
  assign ext_int_req_n_out = s_q.irq_n;
  assign second_port_pin_out = s_q.p2_out;
  assign second_port_pin_oe_out = s_q.p2_oe;

  // ==========================================================================
  // Checks
  AST_GPIO_NO_EXP: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !s_q.exp_en |=> low_pin_oe_out == $past(s_q.low_dir) && low_pin_out == $past(s_q.low_data))
    else $error("low pins not general purpose with expansion off");

  AST_GPIO_EXP_NOADDR: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    s_q.exp_en && !s_q.addr_oe |=> low_pin_oe_out == $past(s_q.low_dir))
    else $error("low pins not general purpose with address output off");

  AST_ADDR_DRIVE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    s_q.exp_en && s_q.addr_oe |=> &low_pin_oe_out)
    else $error("address mode did not enable all low pins");

  AST_ADDR_BITS: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    addr_mode |=> low_pin_out == $past(ext_addr_in))
    else $error("address bit on wrong pin");

  AST_IRQ_ROUTE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    arst_n_in |=> (ext_int_req_n_out & ~$past(s_q.int_sel)) ==
      ($past(low_pin_in) & ~$past(s_q.int_sel)))
    else $error("selected pin level not routed to request");

  AST_IRQ_BLOCK: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    1'b1 |=> (ext_int_req_n_out & $past(s_q.int_sel)) == $past(s_q.int_sel))
    else $error("deselected pin reached request");

  AST_SEL_WRITE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en && addr == ppfs_pkg::OFS_INT_SEL |=> s_q.int_sel == $past(hwdata_in[LOW_PINS-1:0]))
    else $error("select register write lost");

  AST_P2_DIR: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en && addr == ppfs_pkg::OFS_P2_DIR |=> ##1 second_port_pin_oe_out == $past(hwdata_in[7:0], 2))
    else $error("second port enable does not follow direction write");

  AST_P2_DIR_HIDDEN: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    rd_pend && addr == ppfs_pkg::OFS_P2_DIR |=> hrdata_out == ppfs_pkg::WO_READ_VALUE)
    else $error("direction register read back");

  AST_P2_STATE: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    rd_pend && addr == ppfs_pkg::OFS_P2_STATE |=> hrdata_out[7:0] ==
      (($past(s_q.p2_dir) & $past(s_q.p2_data)) | (~$past(s_q.p2_dir) & $past(second_port_pin_in))))
    else $error("pin state read wrong");

  AST_P2_DATA: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en && addr == ppfs_pkg::OFS_P2_DATA |=> ##1 second_port_pin_out == $past(hwdata_in[7:0], 2))
    else $error("second port data not driven");

  AST_P2_DATA_READ: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    rd_pend && addr == ppfs_pkg::OFS_P2_DATA |=>
      hrdata_out[PORT_PINS-1:0] == $past(s_q.p2_data))
    else $error("second port data read back wrong");
endmodule // ppfs_top

// file: verification/ppfs_pin_partner.sv
// Far-side model: outside devices that drive the pins and see the resolved wire levels
`timescale 1ns/1ns
module ppfs_pin_partner (
  input wire logic [5:0] low_pin_out_in,
  input wire logic [5:0] low_pin_oe_in,
  input wire logic [5:0] low_far_in,
  input wire logic [7:0] second_port_pin_out_in,
  input wire logic [7:0] second_port_pin_oe_in,
  input wire logic [7:0] second_far_in,
  output logic [5:0] low_level_out,
  output logic [7:0] second_level_out
);
  // ==========================================================================
  // Wire resolution
  // The block wins where it drives; elsewhere the outside device holds the line,
  // so a released pin never keeps the block's last value
  assign low_level_out = (low_pin_oe_in & low_pin_out_in) | (~low_pin_oe_in & low_far_in);
  assign second_level_out = (second_port_pin_oe_in & second_port_pin_out_in)
    | (~second_port_pin_oe_in & second_far_in);
endmodule // ppfs_pin_partner

// file: verification/tb_port_pin_function_select.sv
// Self-checking bench: register model against pin outputs and read data
`timescale 1ns/1ns
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end
module tb_port_pin_function_select;
  // ==========================================================================
  // Signals
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [5:0] ext_addr = 6'h00;
  logic [5:0] low_far = 6'h00;
  logic [7:0] p2_far = 8'h00;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [5:0] low_lvl, low_out, low_oe, irq_n;
  wire logic [7:0] p2_lvl, p2_out, p2_oe;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'ha24c;
  logic [5:0] cap_addr, cap_lvl, m_ldir, m_ldat, m_isel;
  logic [7:0] m_pdir, m_pdat;
  logic m_exp, m_aoe;
  logic [31:0] rd;

  // Clock; address bus changes every cycle, inputs seen by the block are captured
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cap_addr = ext_addr;
    cap_lvl = low_lvl;
    ext_addr <= 6'($random(seed));
  end

  ppfs_top dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hready_in(hready), .hwdata_in(hwdata),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .low_pin_in(low_lvl), .low_pin_out(low_out), .low_pin_oe_out(low_oe),
    .ext_addr_in(ext_addr), .ext_int_req_n_out(irq_n),
    .second_port_pin_in(p2_lvl), .second_port_pin_out(p2_out), .second_port_pin_oe_out(p2_oe)
  );
  ppfs_pin_partner far (
    .low_pin_out_in(low_out), .low_pin_oe_in(low_oe), .low_far_in(low_far),
    .second_port_pin_out_in(p2_out), .second_port_pin_oe_in(p2_oe), .second_far_in(p2_far),
    .low_level_out(low_lvl), .second_level_out(p2_lvl)
  );

  // ==========================================================================
  // Bus tasks
  // Address phase held until hready is seen high, then data phase likewise
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= ppfs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(hresp, ppfs_pkg::HRESP_OKAY)
  endtask

  // Pin outputs are registered, so they are judged against the captured inputs
  task automatic chk_pins;
    logic am;
    @(negedge mclk_in);
    am = m_exp & m_aoe;
    `CHK(low_oe, am ? 6'h3F : m_ldir)
    `CHK(low_out & low_oe, (am ? cap_addr : m_ldat) & low_oe)
    `CHK(irq_n, m_isel | cap_lvl)
    `CHK(p2_oe, m_pdir)
    `CHK(p2_out, m_pdat)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {m_ldir, m_ldat, m_isel, m_pdir, m_pdat, m_exp, m_aoe} = '0;
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rchk(ppfs_pkg::OFS_P2_DIR, ppfs_pkg::WO_READ_VALUE);
    rchk(ppfs_pkg::OFS_P2_DATA, 32'h0000_0000);
    rchk(ppfs_pkg::OFS_INT_SEL, 32'h0000_0000);
    rchk(8'h20, ppfs_pkg::UNMAPPED_READ);
    chk_pins;
    // Every expansion / address-enable combination, random bits elsewhere
    for (int i = 0; i < 16; i++) begin
      m_ldir = 6'($random(seed));
      m_ldat = 6'($random(seed));
      m_isel = 6'($random(seed));
      m_pdir = 8'($random(seed));
      m_pdat = 8'($random(seed));
      m_exp = i[0];
      m_aoe = i[1];
      low_far <= 6'($random(seed));
      p2_far <= 8'($random(seed));
      xfer(1'b1, ppfs_pkg::OFS_LOW_DIR, {26'h0, m_ldir});
      xfer(1'b1, ppfs_pkg::OFS_LOW_DATA, {26'h0, m_ldat});
      xfer(1'b1, ppfs_pkg::OFS_MODE_CTRL, {31'h0, m_exp});
      xfer(1'b1, ppfs_pkg::OFS_FUNC_CTRL, {31'h0, m_aoe});
      xfer(1'b1, ppfs_pkg::OFS_INT_SEL, {26'h0, m_isel});
      xfer(1'b1, ppfs_pkg::OFS_P2_DIR, {24'h0, m_pdir});
      xfer(1'b1, ppfs_pkg::OFS_P2_DATA, {24'h0, m_pdat});
      // Pin-state register is read only: this write must change nothing
      xfer(1'b1, ppfs_pkg::OFS_P2_STATE, $random(seed));
      repeat (3) chk_pins;
      rchk(ppfs_pkg::OFS_P2_DIR, ppfs_pkg::WO_READ_VALUE);
      rchk(ppfs_pkg::OFS_LOW_DIR, ppfs_pkg::WO_READ_VALUE);
      rchk(ppfs_pkg::OFS_P2_DATA, {24'h0, m_pdat});
      rchk(ppfs_pkg::OFS_LOW_DATA, {26'h0, m_ldat});
      rchk(ppfs_pkg::OFS_INT_SEL, {26'h0, m_isel});
      rchk(ppfs_pkg::OFS_MODE_CTRL, {31'h0, m_exp});
      rchk(ppfs_pkg::OFS_FUNC_CTRL, {31'h0, m_aoe});
      rchk(ppfs_pkg::OFS_P2_STATE, {24'h0, (m_pdir & m_pdat) | (~m_pdir & p2_far)});
    end
    tally_and_finish;
  end

  // Watchdog well beyond the thousand or so cycles the sequence needs
  initial begin
    #500000;
    errors++;
    tally_and_finish;
  end
endmodule // tb_port_pin_function_select
